// ---- src/cel_comparator_event_logic.sv ----
// comparator event logic: adc triggers, interrupts, reference select, axi4-lite registers
// Operation
// - trigger select none never asserts the adc trigger
// - level trigger asserts while output high or low per polarity
// - edge trigger pulses on rising, falling, or any edge as chosen
// - level interrupt sets status while output high or low
// - edge interrupt sets status on falling, rising, or either edge
// - interrupt and trigger conditions held and evaluated independently
// - pin output is the comparator result, straight or inverted
// - reference source: own pin, first comparator pin, or internal ladder
// - comparator 0 shared-pin choice equals its own pin
// - shared internal reference: off or one of 28 levels; the code takes any of 31 nonzero 5-bit levels
// - software clear deasserts interrupt status
// - level interrupt clear fails while the level still holds
// - per-comparator enable gates raw status onto the interrupt
// - software reads raw or masked status per comparator
// - software reads the live comparator output
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cel_comparator_event_logic (
    input  wire logic                              sys_clk,
    input  wire logic                              rst_n,
    input  wire logic [cel_pkg::ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [cel_pkg::ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic [cel_pkg::NUM_COMP-1:0]      comp_raw,
    output logic [cel_pkg::NUM_COMP-1:0]           comp_pin_out,
    output logic [cel_pkg::NUM_COMP-1:0]           adc_trigger,
    output logic [1:0]                             ref_source_sel [cel_pkg::NUM_COMP],
    output logic [cel_pkg::REF_W-1:0]              ref_level,
    output logic                                   comp_irq,
    output logic                                   event_irq
);
    localparam int N = cel_pkg::NUM_COMP;
    localparam logic [7:0] CTRL_END = 8'(N) * cel_pkg::CTRL_STRIDE;

    cel_pkg::cel_cfg_t        cfg [N];
    logic [cel_pkg::REF_W-1:0] ref_reg;
    logic [N-1:0]             sync1;
    logic [N-1:0]             sync2;
    logic [N-1:0]             prev;
    logic [N-1:0]             ris;
    logic [N-1:0]             ien;
    logic [N-1:0]             int_cond;
    logic [N-1:0]             trig_cond;
    logic [N-1:0]             int_level;
    logic [2*N-1:0]           evt;
    logic [2*N-1:0]           evt_mask;
    logic [2*N-1:0]           evt_src;
    logic [N-1:0]             clr_req;

    // axi write side state, plus read handshake and event-read strobes
    logic [cel_pkg::ADDR_W-1:0] aw_addr;
    logic                     aw_held;
    logic [31:0]              w_data;
    logic                     w_held;
    logic                     wr_go;
    logic                     wr_hit;
    logic                     rd_go;
    logic                     rd_evt;

    // comparator input synchroniser; first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
            prev  <= '0;
        end
        else
        begin
            sync1 <= comp_raw;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // per-comparator condition decode, trigger and interrupt apart
    for (genvar i = 0; i < N; i++)
    begin : g_cond
        logic rise;
        logic fall;
        assign rise = sync2[i] & ~prev[i];
        assign fall = ~sync2[i] & prev[i];

        always_comb
        begin
            case (cel_pkg::cel_trig_t'(cfg[i].trig))
                cel_pkg::adc_trigger_disabled:        trig_cond[i] = 1'b0;
                cel_pkg::adc_trigger_on_high_level:   trig_cond[i] = sync2[i];
                cel_pkg::adc_trigger_on_low_level:    trig_cond[i] = ~sync2[i];
                cel_pkg::adc_trigger_on_falling_edge: trig_cond[i] = fall;
                cel_pkg::adc_trigger_on_rising_edge:  trig_cond[i] = rise;
                cel_pkg::adc_trigger_on_any_edge:     trig_cond[i] = rise | fall;
                default:                              trig_cond[i] = 1'b0;
            endcase
        end

        always_comb
        begin
            int_level[i] = 1'b0;
            case (cel_pkg::cel_int_t'(cfg[i].intsel))
                cel_pkg::int_on_high_level:
                begin
                    int_cond[i]  = sync2[i];
                    int_level[i] = 1'b1;
                end
                cel_pkg::int_on_low_level:
                begin
                    int_cond[i]  = ~sync2[i];
                    int_level[i] = 1'b1;
                end
                cel_pkg::int_on_falling_edge: int_cond[i] = fall;
                cel_pkg::int_on_rising_edge:  int_cond[i] = rise;
                cel_pkg::int_on_any_edge:     int_cond[i] = rise | fall;
                default:                      int_cond[i] = 1'b0;
            endcase
        end
    end

    // trigger, pin and reference outputs all registered
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adc_trigger  <= '0;
            comp_pin_out <= '0;
            ref_level    <= cel_pkg::REF_OFF;
            for (int k = 0; k < N; k++)
                ref_source_sel[k] <= cel_pkg::SRC_RESET;
        end
        else
        begin
            adc_trigger <= trig_cond;
            ref_level   <= ref_reg;
            for (int k = 0; k < N; k++)
            begin
                comp_pin_out[k] <= sync2[k] ^ cfg[k].invert;
                // comparator 0 has no separate shared pin
                if (k == 0 && cfg[k].src == cel_pkg::ref_source_shared_first_pin)
                    ref_source_sel[k] <= cel_pkg::ref_source_own_pin;
                else
                    ref_source_sel[k] <= cfg[k].src;
            end
        end
    end

    // axi write address/data capture, either order
    assign wr_go  = aw_held && w_held && !s_axi_bvalid;
    assign rd_go  = s_axi_arvalid && s_axi_arready;
    assign wr_hit = (aw_addr < cel_pkg::OFF_CTRL0 + CTRL_END) || aw_addr == cel_pkg::OFF_REF
                    || aw_addr == cel_pkg::OFF_IEN || aw_addr == cel_pkg::OFF_ICLR
                    || aw_addr == cel_pkg::OFF_EVT_MASK;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cel_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data       <= s_axi_wdata;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? cel_pkg::RESP_OKAY : cel_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // configuration registers; byte strobes ignored, whole word written
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_reg  <= cel_pkg::REF_OFF;
            ien      <= '0;
            evt_mask <= '0;
            for (int k = 0; k < N; k++)
                cfg[k] <= '{cel_pkg::TRIG_RESET, cel_pkg::INT_RESET, cel_pkg::SRC_RESET, 1'b0};
        end
        else if (wr_go)
        begin
            for (int k = 0; k < N; k++)
                if (aw_addr == cel_pkg::OFF_CTRL0 + 8'(k) * cel_pkg::CTRL_STRIDE)
                begin
                    cfg[k].trig   <= w_data[cel_pkg::TRIG_LSB +: 3];
                    cfg[k].intsel <= w_data[cel_pkg::INT_LSB +: 3];
                    cfg[k].src    <= w_data[cel_pkg::SRC_LSB +: 2];
                    cfg[k].invert <= w_data[cel_pkg::INV_BIT];
                end
            if (aw_addr == cel_pkg::OFF_REF)
                ref_reg <= w_data[cel_pkg::REF_W-1:0];
            if (aw_addr == cel_pkg::OFF_IEN)
                ien <= w_data[N-1:0];
            if (aw_addr == cel_pkg::OFF_EVT_MASK)
                evt_mask <= w_data[2*N-1:0];
        end
    end

    // write-one-to-clear request for comparator interrupt status
    assign clr_req = (wr_go && aw_addr == cel_pkg::OFF_ICLR) ? w_data[N-1:0] : '0;

    // raw status: set wins over clear; level source blocks the clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ris <= '0;
        else
            for (int k = 0; k < N; k++)
                if (int_cond[k])
                    ris[k] <= 1'b1;
                else if (clr_req[k])
                    ris[k] <= 1'b0;
        end

    // comparator interrupt gated by enables
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            comp_irq <= 1'b0;
        else
            comp_irq <= |(ris & ien);
    end

    // system event block: trigger and interrupt conditions as decoded, levels included, cleared on read
    assign evt_src = {trig_cond, int_cond};
    assign rd_evt  = rd_go && s_axi_araddr == cel_pkg::OFF_EVT;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            evt <= '0;
        else
            evt <= evt_src | (rd_evt ? '0 : evt);         // set wins over read clear
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            event_irq <= 1'b0;
        else
            event_irq <= |(evt & evt_mask);
    end

    // axi read channel, one cycle after address taken
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= cel_pkg::RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= cel_pkg::RESP_OKAY;
            s_axi_rdata   <= '0;
            if (s_axi_araddr < CTRL_END)
            begin
                for (int k = 0; k < N; k++)
                    if (s_axi_araddr == 8'(k) * cel_pkg::CTRL_STRIDE)
                    begin
                        s_axi_rdata[cel_pkg::TRIG_LSB +: 3] <= cfg[k].trig;
                        s_axi_rdata[cel_pkg::INT_LSB +: 3]  <= cfg[k].intsel;
                        s_axi_rdata[cel_pkg::SRC_LSB +: 2]  <= cfg[k].src;
                        s_axi_rdata[cel_pkg::INV_BIT]       <= cfg[k].invert;
                    end
            end
            else
                case (s_axi_araddr)
                    cel_pkg::OFF_REF:      s_axi_rdata[cel_pkg::REF_W-1:0] <= ref_reg;
                    cel_pkg::OFF_RIS:      s_axi_rdata[N-1:0] <= ris;
                    cel_pkg::OFF_IEN:      s_axi_rdata[N-1:0] <= ien;
                    cel_pkg::OFF_MIS:      s_axi_rdata[N-1:0] <= ris & ien;
                    cel_pkg::OFF_ICLR:     s_axi_rdata[N-1:0] <= '0;
                    cel_pkg::OFF_VALUE:    s_axi_rdata[N-1:0] <= sync2;
                    cel_pkg::OFF_EVT:      s_axi_rdata[2*N-1:0] <= evt;
                    cel_pkg::OFF_EVT_MASK: s_axi_rdata[2*N-1:0] <= evt_mask;
                    default:               s_axi_rresp <= cel_pkg::RESP_SLVERR;
                endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks, aimed at the comparators that the bench actually drives
    a_trig_none_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg[2].trig == cel_pkg::adc_trigger_disabled |=> !adc_trigger[2])
        else $error("trigger while disabled");
    a_trig_high_lvl: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg[2].trig == cel_pkg::adc_trigger_on_high_level && sync2[2] |=> adc_trigger[2])
        else $error("high level no trig");
    a_trig_rise_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg[2].trig == cel_pkg::adc_trigger_on_rising_edge && $rose(sync2[2]) |=> adc_trigger[2])
        else $error("rise no trig");
    a_int_level_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg[2].intsel == cel_pkg::int_on_low_level && !sync2[2] |=> ris[2])
        else $error("low level no status");
    a_int_fall_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg[2].intsel == cel_pkg::int_on_falling_edge && $fell(sync2[2]) |=> ris[2])
        else $error("fall no status");
    a_pin_polarity: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 comp_pin_out[1] == ($past(sync2[1]) ^ $past(cfg[1].invert)))
        else $error("pin wrong");
    a_src_zero_alias: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg[0].src == cel_pkg::ref_source_shared_first_pin
        |=> ref_source_sel[0] == cel_pkg::ref_source_own_pin) else $error("shared pin alias");
    a_clear_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clr_req[2] && !int_cond[2] |=> !ris[2])
        else $error("clear ignored");
    a_level_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        int_level[2] && int_cond[2] |=> ris[2])
        else $error("level cleared early");
    a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 comp_irq == |($past(ris) & $past(ien)))
        else $error("irq gating");
    a_event_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 event_irq == |($past(evt) & $past(evt_mask)))
        else $error("event irq gating");
    c_edge_trig: cover property (@(posedge sys_clk) disable iff (!rst_n) adc_trigger[2] ##1 !adc_trigger[2]);
    c_irq_raise: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(comp_irq));
    c_clear_hit: cover property (@(posedge sys_clk) disable iff (!rst_n) |clr_req ##1 !comp_irq);
    c_event_raise: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(event_irq));
endmodule : cel_comparator_event_logic
`default_nettype wire

// ---- src/cel_pkg.sv ----
// package for the comparator event logic: register map, field layout, encodings
package cel_pkg;
    localparam int          NUM_COMP        = 3;
    localparam int          ADDR_W          = 8;
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL0       = 8'h00;
    localparam logic [7:0]  OFF_CTRL1       = 8'h04;
    localparam logic [7:0]  OFF_CTRL2       = 8'h08;
    localparam logic [7:0]  OFF_REF         = 8'h10;
    localparam logic [7:0]  OFF_RIS         = 8'h14;
    localparam logic [7:0]  OFF_IEN         = 8'h18;
    localparam logic [7:0]  OFF_MIS         = 8'h1c;
    localparam logic [7:0]  OFF_ICLR        = 8'h20;
    localparam logic [7:0]  OFF_VALUE       = 8'h24;
    localparam logic [7:0]  OFF_EVT         = 8'h28;
    localparam logic [7:0]  OFF_EVT_MASK    = 8'h2c;
    localparam logic [7:0]  CTRL_STRIDE     = 8'h04;
    // control word field positions
    localparam int          TRIG_LSB        = 0;
    localparam int          INT_LSB         = 4;
    localparam int          SRC_LSB         = 8;
    localparam int          INV_BIT         = 12;
    localparam int          REF_W           = 5;
    localparam logic [4:0]  REF_OFF         = 5'h00;
    localparam logic [2:0]  TRIG_RESET      = 3'h0;
    localparam logic [2:0]  INT_RESET       = 3'h1;
    localparam logic [1:0]  SRC_RESET       = 2'h0;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // adc trigger condition
    typedef enum logic [2:0] {
        adc_trigger_disabled        = 3'h0,
        adc_trigger_on_high_level   = 3'h1,
        adc_trigger_on_low_level    = 3'h2,
        adc_trigger_on_falling_edge = 3'h3,
        adc_trigger_on_rising_edge  = 3'h4,
        adc_trigger_on_any_edge     = 3'h5
    } cel_trig_t;

    // interrupt condition, same codes without a disabled choice
    typedef enum logic [2:0] {
        int_on_high_level   = 3'h1,
        int_on_low_level    = 3'h2,
        int_on_falling_edge = 3'h3,
        int_on_rising_edge  = 3'h4,
        int_on_any_edge     = 3'h5
    } cel_int_t;

    typedef enum logic [1:0] {
        ref_source_own_pin          = 2'h0,
        ref_source_shared_first_pin = 2'h1,
        ref_source_internal_ladder  = 2'h2
    } cel_src_t;

    // per-comparator configuration
    typedef struct packed {
        logic [2:0] trig;
        logic [2:0] intsel;
        logic [1:0] src;
        logic       invert;
    } cel_cfg_t;
endpackage : cel_pkg

// ---- verification/cel_adc_irq_model.sv ----
// far-side model: adc sequencer trigger input and processor interrupt input
`timescale 1ns/10ps
`default_nettype none
module cel_adc_irq_model (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic                         clr,
    input  wire logic [cel_pkg::NUM_COMP-1:0] adc_trigger,
    input  wire logic                         comp_irq,
    output logic      [7:0]                   trig_high [cel_pkg::NUM_COMP],
    output logic      [7:0]                   trig_starts [cel_pkg::NUM_COMP],
    output logic                              irq_seen
);
    logic [cel_pkg::NUM_COMP-1:0] prev_trig;
    // sequencer side counts busy cycles and trigger starts; level or pulse alike
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_trig <= '0;
            irq_seen  <= 1'b0;
            for (int i = 0; i < cel_pkg::NUM_COMP; i++)
            begin
                trig_high[i]   <= 8'h00;
                trig_starts[i] <= 8'h00;
            end
        end
        else
        begin
            prev_trig <= adc_trigger;
            irq_seen  <= comp_irq;
            for (int i = 0; i < cel_pkg::NUM_COMP; i++)
            begin
                trig_high[i]   <= clr ? 8'h00 : trig_high[i] + 8'(adc_trigger[i]);
                trig_starts[i] <= clr ? 8'h00
                                : trig_starts[i] + 8'(adc_trigger[i] & ~prev_trig[i]);
            end
        end
    end
endmodule : cel_adc_irq_model
`default_nettype wire

// ---- verification/test_cel_comparator_event_logic.sv ----
// self-checking bench for the comparator event logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module test_cel_comparator_event_logic;
    logic        sys_clk, rst_n, clr;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, comp_irq, event_irq, irq_seen;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  comp_raw, pin_out, adc_trigger;
    logic [1:0]  src_sel [cel_pkg::NUM_COMP];
    logic [4:0]  ref_level;
    logic [7:0]  trig_high [cel_pkg::NUM_COMP];
    logic [7:0]  trig_starts [cel_pkg::NUM_COMP];
    int          num_errors, n_compared, cycles;
    logic [7:0]  exp_high [6] = '{8'd0, 8'd10, 8'd20, 8'd1, 8'd1, 8'd2};
    logic [7:0]  exp_starts [6] = '{8'd0, 8'd1, 8'd1, 8'd1, 8'd1, 8'd2};

    cel_comparator_event_logic i_cel_comparator_event_logic (
        .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .comp_raw(comp_raw), .comp_pin_out(pin_out), .adc_trigger(adc_trigger),
        .ref_source_sel(src_sel), .ref_level(ref_level), .comp_irq(comp_irq),
        .event_irq(event_irq));
    cel_adc_irq_model i_cel_adc_irq_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .clr(clr), .adc_trigger(adc_trigger),
        .comp_irq(comp_irq), .trig_high(trig_high), .trig_starts(trig_starts),
        .irq_seen(irq_seen));

    // free-running clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // hang guard, far above the several hundred cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;  awvalid <= 1'b1;  wdata <= d;  wvalid <= 1'b1;  bready <= 1'b1;
        while (!done)
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : wr

    task automatic rdreg(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        araddr <= a;  arvalid <= 1'b1;  rready <= 1'b1;
        while (!done)
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : rdreg

    task automatic settle();
        repeat (8) @(posedge sys_clk);
    endtask : settle

    initial
    begin
        rst_n = 1'b0;  clr = 1'b0;  comp_raw = 3'h0;  wstrb = 4'hf;  cycles = 0;
        awaddr = 8'h00;  awvalid = 1'b0;  wdata = 32'h0;  wvalid = 1'b0;  bready = 1'b0;
        araddr = 8'h00;  arvalid = 1'b0;  rready = 1'b0;  num_errors = 0;  n_compared = 0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        // reset values, refused accesses
        rdreg(cel_pkg::OFF_CTRL0);  `CHK("ctrl0 reset", 32'h00000010, rd)
        rdreg(8'h3c);  `CHK("unmapped resp", cel_pkg::RESP_SLVERR, rs)
        wr(cel_pkg::OFF_RIS, 32'h7);  `CHK("ris write resp", cel_pkg::RESP_SLVERR, rs)
        $display("test reset done");
        // pin polarity and live value
        wr(cel_pkg::OFF_CTRL1, 32'h00001000);
        comp_raw <= 3'h5;
        settle();
        `CHK("pin out", 3'h7, pin_out)
        rdreg(cel_pkg::OFF_VALUE);  `CHK("value", 32'h00000005, rd)
        wr(cel_pkg::OFF_CTRL1, 32'h00000100);  comp_raw <= 3'h0;
        wr(cel_pkg::OFF_CTRL0, 32'h00000100);  wr(cel_pkg::OFF_CTRL2, 32'h00000200);
        settle();
        `CHK("src0", 2'h0, src_sel[0])
        `CHK("src1", 2'h1, src_sel[1])
        `CHK("src2", 2'h2, src_sel[2])
        wr(cel_pkg::OFF_REF, 32'h0000001c);  rdreg(cel_pkg::OFF_REF);
        `CHK("ref level", 5'h1c, ref_level)
        `CHK("ref read", 32'h0000001c, rd)
        $display("test pins done");
        // every trigger code over one rise and one fall of comparator 2
        for (int c = 0; c < 6; c++)
        begin
            wr(cel_pkg::OFF_CTRL2, 32'(c) | 32'h00000030);
            settle();
            @(posedge sys_clk);  clr <= 1'b1;
            @(posedge sys_clk);  clr <= 1'b0;
            repeat (10) @(posedge sys_clk);
            comp_raw[2] <= 1'b1;
            repeat (10) @(posedge sys_clk);
            comp_raw[2] <= 1'b0;
            repeat (11) @(posedge sys_clk);
            `CHK("trig cycles", exp_high[c], trig_high[2])
            `CHK("trig starts", exp_starts[c], trig_starts[2])
        end
        $display("test triggers done");
        // rise triggers while fall interrupts
        wr(cel_pkg::OFF_CTRL2, 32'h00000034);  wr(cel_pkg::OFF_ICLR, 32'h7);
        comp_raw[2] <= 1'b1;  settle();
        rdreg(cel_pkg::OFF_RIS);  `CHK("ris after rise", 1'b0, rd[2])
        comp_raw[2] <= 1'b0;  settle();
        rdreg(cel_pkg::OFF_RIS);  `CHK("ris after fall", 1'b1, rd[2])
        rdreg(cel_pkg::OFF_MIS);  `CHK("mis masked", 1'b0, rd[2])
        `CHK("irq masked", 1'b0, irq_seen)
        wr(cel_pkg::OFF_IEN, 32'h4);  settle();
        `CHK("irq enabled", 1'b1, irq_seen)
        rdreg(cel_pkg::OFF_MIS);  `CHK("mis set", 1'b1, rd[2])
        wr(cel_pkg::OFF_ICLR, 32'h4);  settle();
        `CHK("irq cleared", 1'b0, irq_seen)
        rdreg(cel_pkg::OFF_RIS);  `CHK("ris cleared", 1'b0, rd[2])
        $display("test interrupts done");
        // low level interrupt cannot be cleared while the level holds
        wr(cel_pkg::OFF_CTRL2, 32'h00000020);  settle();
        wr(cel_pkg::OFF_ICLR, 32'h4);  settle();
        rdreg(cel_pkg::OFF_RIS);  `CHK("level held", 1'b1, rd[2])
        comp_raw[2] <= 1'b1;  settle();
        wr(cel_pkg::OFF_ICLR, 32'h4);  settle();
        rdreg(cel_pkg::OFF_RIS);  `CHK("level ended", 1'b0, rd[2])
        `CHK("irq level ended", 1'b0, irq_seen)
        $display("test level done");
        // system events: sticky, cleared by a read, gated by their mask
        rdreg(cel_pkg::OFF_EVT);  rdreg(cel_pkg::OFF_EVT);
        `CHK("evt read clear", 32'h00000000, rd)
        `CHK("event irq masked", 1'b0, event_irq)
        wr(cel_pkg::OFF_EVT_MASK, 32'h4);  comp_raw[2] <= 1'b0;  settle();
        `CHK("event irq set", 1'b1, event_irq)
        comp_raw[2] <= 1'b1;  settle();  rdreg(cel_pkg::OFF_EVT);
        `CHK("evt level seen", 32'h00000004, rd)
        settle();
        `CHK("event irq cleared", 1'b0, event_irq)
        $display("test events done");
        test_done();
    end
endmodule : test_cel_comparator_event_logic
`default_nettype wire
